/* design/capture_value_store.sv */
// per-module compare and auto-reload value storage with registered read port
`timescale 1ns/1ps
`include "counter_array_consts.svh"
module capture_value_store #(
    parameter int num_modules = `CCR_NUM_MODULES,
    parameter int value_w = `CCR_VALUE_W
) (
    input wire logic core_clk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [num_modules-1:0] write_low, // one-hot low byte write
    input wire logic [num_modules-1:0] write_high, // one-hot high byte write
    input wire logic [num_modules-1:0] read_low, // one-hot low byte read
    input wire logic [num_modules-1:0] read_high, // one-hot high byte read
    input wire logic reload_select, // 1 reaches reload values
    input wire logic [7:0] wdata, // write byte
    output logic [7:0] rdata, // registered read byte
    output logic [num_modules*value_w-1:0] compare_flat, // compare values
    output logic [num_modules*value_w-1:0] reload_flat // reload values
);
    logic [7:0] next_rdata;

    // ****************************************
    // storage
    // ****************************************
    for (genvar i = 0; i < num_modules; i++) begin : g_mod
        always_ff @(posedge core_clk) begin
            if (srst) begin
                compare_flat[i*value_w +: value_w] <= `CCR_RST_VALUE; // [R4] [R5]
                reload_flat[i*value_w +: value_w] <= `CCR_RST_VALUE;
            end else if (reload_select) begin // [R8] [R13]
                if (write_low[i]) begin
                    reload_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W] <= wdata; // [R6]
                end
                if (write_high[i]) begin
                    reload_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W] <= wdata; // [R7]
                end
            end else begin
                if (write_low[i]) begin
                    compare_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W] <= wdata; // [R4]
                end
                if (write_high[i]) begin
                    compare_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W] <= wdata; // [R5]
                end
            end
        end

        property p_store_low;
            @(posedge core_clk) disable iff (srst)
            (write_low[i] && !reload_select) |=>
                compare_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W] == $past(wdata);
        endproperty
        a_store_low: assert property (p_store_low) // [R4]
            else $error("compare low byte not stored");

        property p_store_high;
            @(posedge core_clk) disable iff (srst)
            (write_high[i] && !reload_select) |=>
                compare_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W] == $past(wdata);
        endproperty
        a_store_high: assert property (p_store_high) // [R5]
            else $error("compare high byte not stored");

        property p_reload_low;
            @(posedge core_clk) disable iff (srst)
            (write_low[i] && reload_select) |=>
                reload_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W] == $past(wdata)
                && $stable(compare_flat[i*value_w +: value_w]);
        endproperty
        a_reload_low: assert property (p_reload_low) // [R6]
            else $error("reload low byte not stored or compare disturbed");

        property p_reload_high;
            @(posedge core_clk) disable iff (srst)
            (write_high[i] && reload_select) |=>
                reload_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W] == $past(wdata)
                && $stable(compare_flat[i*value_w +: value_w]);
        endproperty
        a_reload_high: assert property (p_reload_high) // [R7]
            else $error("reload high byte not stored or compare disturbed");
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        next_rdata = `CCR_RST_BYTE;
        for (int i = 0; i < num_modules; i++) begin
            if (read_low[i]) begin
                next_rdata = reload_select ? // [R8] [R13]
                    reload_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W] :
                    compare_flat[i*value_w + `CCR_LOW_LSB +: `CCR_BYTE_W];
            end
            if (read_high[i]) begin
                next_rdata = reload_select ?
                    reload_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W] :
                    compare_flat[i*value_w + `CCR_HIGH_LSB +: `CCR_BYTE_W];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= `CCR_RST_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

/* design/counter_array_capture_regs.sv */
// counter array count, snapshot, compare/reload access and comparator enables
`timescale 1ns/1ps
`include "counter_array_consts.svh"
module counter_array_capture_regs (
    input wire logic core_clk, // system clock, 250 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic sfr_rd, // read strobe, one cycle
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata, // read data, two cycles after sfr_rd
    output logic sfr_rvalid, // read data valid pulse
    output logic sfr_rhit, // read address was mapped
    input wire logic count_tick, // counting engine advance pulse
    input wire logic watchdog_lock, // blocks count writes when 1
    input wire logic reload_select, // 1 routes module bytes to reload values
    input wire logic [`CCR_NUM_MODULES-1:0] mode_ecom_wr, // mode register writes
    input wire logic [`CCR_NUM_MODULES-1:0] mode_ecom_wdata, // enable values written
    output logic [`CCR_NUM_MODULES-1:0] comparator_enable, // per-module enable
    output logic [`CCR_NUM_MODULES-1:0] match, // compare match per module
    output logic [`CCR_VALUE_W-1:0] count_value, // running count
    output logic [`CCR_NUM_MODULES*`CCR_VALUE_W-1:0] compare_value, // compare values
    output logic [`CCR_NUM_MODULES*`CCR_VALUE_W-1:0] reload_value // reload values
);
    localparam int n_mod = `CCR_NUM_MODULES;
    localparam int val_w = `CCR_VALUE_W;

    localparam logic [7:0] low_addr [n_mod] = '{
        `CCR_ADDR_MOD0_LOW, `CCR_ADDR_MOD1_LOW, `CCR_ADDR_MOD2_LOW,
        `CCR_ADDR_MOD3_LOW, `CCR_ADDR_MOD4_LOW, `CCR_ADDR_MOD5_LOW
    };
    localparam logic [7:0] high_addr [n_mod] = '{
        `CCR_ADDR_MOD0_HIGH, `CCR_ADDR_MOD1_HIGH, `CCR_ADDR_MOD2_HIGH,
        `CCR_ADDR_MOD3_HIGH, `CCR_ADDR_MOD4_HIGH, `CCR_ADDR_MOD5_HIGH
    };

    logic [n_mod-1:0] low_hit;
    logic [n_mod-1:0] high_hit;
    logic [n_mod-1:0] wr_low;
    logic [n_mod-1:0] wr_high;
    logic count_low_hit;
    logic count_high_hit;
    counter_array_pkg::byte_t snapshot;
    counter_array_pkg::byte_t store_rdata;
    counter_array_pkg::byte_t local_rdata;
    counter_array_pkg::read_source_t next_source;
    counter_array_pkg::read_source_t read_source;
    logic read_stage;

    // ****************************************
    // address decode
    // ****************************************
    for (genvar i = 0; i < n_mod; i++) begin : g_decode
        assign low_hit[i] = (sfr_addr == low_addr[i]);
        assign high_hit[i] = (sfr_addr == high_addr[i]);
    end

    assign wr_low = sfr_wr ? low_hit : '0;
    assign wr_high = sfr_wr ? high_hit : '0;
    assign count_low_hit = (sfr_addr == `CCR_ADDR_COUNT_LOW);
    assign count_high_hit = (sfr_addr == `CCR_ADDR_COUNT_HIGH);

    // ****************************************
    // running count
    // ****************************************
    // software writes win over a tick in the same cycle unless watchdog_lock is set, so a written
    // byte is never overtaken by the engine on its way in
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_value <= `CCR_RST_VALUE; // [R1]
        end else if (sfr_wr && count_low_hit) begin
            if (!watchdog_lock) begin // [R12]
                count_value[`CCR_LOW_MSB:`CCR_LOW_LSB] <= sfr_wdata;
            end else if (count_tick) begin
                count_value <= count_value + `CCR_COUNT_STEP;
            end
        end else if (sfr_wr && count_high_hit) begin
            if (!watchdog_lock) begin // [R3]
                count_value[`CCR_HIGH_MSB:`CCR_HIGH_LSB] <= sfr_wdata; // [R1]
            end else if (count_tick) begin
                count_value <= count_value + `CCR_COUNT_STEP;
            end
        end else if (count_tick) begin
            count_value <= count_value + `CCR_COUNT_STEP;
        end
    end

    // ****************************************
    // high byte snapshot
    // ****************************************
    // loading on the low read lets software read a coherent 16-bit value
    // low byte first even while the count keeps running
    always_ff @(posedge core_clk) begin
        if (srst) begin
            snapshot <= `CCR_RST_BYTE;
        end else if (sfr_rd && count_low_hit) begin
            snapshot <= count_value[`CCR_HIGH_MSB:`CCR_HIGH_LSB]; // [R2]
        end
    end

    // ****************************************
    // comparator enables
    // ****************************************
    // a bus write and a mode write cannot share a cycle on one bus;
    // the byte write still takes priority should it happen
    always_ff @(posedge core_clk) begin
        if (srst) begin
            comparator_enable <= '0;
        end else begin
            for (int i = 0; i < n_mod; i++) begin
                if (wr_low[i]) begin
                    comparator_enable[i] <= 1'b0; // [R9]
                end else if (wr_high[i]) begin
                    comparator_enable[i] <= 1'b1; // [R10]
                end else if (mode_ecom_wr[i]) begin
                    comparator_enable[i] <= mode_ecom_wdata[i];
                end
            end
        end
    end

    // ****************************************
    // compare match
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            match <= '0;
        end else begin
            for (int i = 0; i < n_mod; i++) begin
                match[i] <= comparator_enable[i] &&
                    (count_value == compare_value[i*val_w +: val_w]); // [R11]
            end
        end
    end

    // ****************************************
    // value storage
    // ****************************************
    capture_value_store #(
        .num_modules(n_mod),
        .value_w(val_w)
    ) u_store (
        .core_clk(core_clk),
        .srst(srst),
        .write_low(wr_low),
        .write_high(wr_high),
        .read_low(sfr_rd ? low_hit : '0),
        .read_high(sfr_rd ? high_hit : '0),
        .reload_select(reload_select),
        .wdata(sfr_wdata),
        .rdata(store_rdata),
        .compare_flat(compare_value),
        .reload_flat(reload_value)
    );

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        if (!sfr_rd) begin
            next_source = counter_array_pkg::SRC_NONE;
        end else if (count_low_hit) begin
            next_source = counter_array_pkg::SRC_COUNT_LOW;
        end else if (count_high_hit) begin
            next_source = counter_array_pkg::SRC_COUNT_HIGH;
        end else if (|low_hit || |high_hit) begin
            next_source = counter_array_pkg::SRC_MODULE;
        end else begin
            next_source = counter_array_pkg::SRC_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            read_stage <= 1'b0;
            read_source <= counter_array_pkg::SRC_NONE;
            local_rdata <= `CCR_RST_BYTE;
        end else begin
            read_stage <= sfr_rd;
            read_source <= next_source;
            if (next_source == counter_array_pkg::SRC_COUNT_HIGH) begin
                local_rdata <= snapshot; // [R2]
            end else begin
                local_rdata <= count_value[`CCR_LOW_MSB:`CCR_LOW_LSB];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sfr_rdata <= `CCR_RST_BYTE;
            sfr_rvalid <= 1'b0;
            sfr_rhit <= 1'b0;
        end else begin
            sfr_rvalid <= read_stage;
            sfr_rhit <= read_source != counter_array_pkg::SRC_NONE;
            unique case (read_source)
                counter_array_pkg::SRC_NONE: begin
                    sfr_rdata <= `CCR_RST_BYTE;
                end
                counter_array_pkg::SRC_COUNT_LOW,
                counter_array_pkg::SRC_COUNT_HIGH: begin
                    sfr_rdata <= local_rdata;
                end
                counter_array_pkg::SRC_MODULE: begin
                    sfr_rdata <= store_rdata;
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_count_reset;
        @(posedge core_clk)
        srst |=> count_value == `CCR_RST_VALUE && snapshot == `CCR_RST_BYTE;
    endproperty
    a_count_reset: assert property (p_count_reset) // [R1]
        else $error("count not zero after reset");

    property p_high_write;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && count_high_hit && !watchdog_lock) |=>
            count_value[`CCR_HIGH_MSB:`CCR_HIGH_LSB] == $past(sfr_wdata);
    endproperty
    a_high_write: assert property (p_high_write) // [R1]
        else $error("count high byte write lost");

    property p_snapshot_load;
        @(posedge core_clk) disable iff (srst)
        (sfr_rd && count_low_hit) |=>
            snapshot == $past(count_value[`CCR_HIGH_MSB:`CCR_HIGH_LSB]);
    endproperty
    a_snapshot_load: assert property (p_snapshot_load) // [R2]
        else $error("snapshot did not load on low byte read");

    property p_snapshot_hold;
        @(posedge core_clk) disable iff (srst)
        !(sfr_rd && count_low_hit) |=> $stable(snapshot);
    endproperty
    a_snapshot_hold: assert property (p_snapshot_hold) // [R2]
        else $error("snapshot changed without low byte read");

    property p_high_read;
        @(posedge core_clk) disable iff (srst)
        (sfr_rd && count_high_hit && !sfr_wr) |-> ##2
            (sfr_rvalid && sfr_rhit && sfr_rdata == $past(snapshot, 2));
    endproperty
    a_high_read: assert property (p_high_read) // [R2]
        else $error("high byte read did not return snapshot");

    property p_high_locked;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && count_high_hit && watchdog_lock && !count_tick) |=>
            $stable(count_value);
    endproperty
    a_high_locked: assert property (p_high_locked) // [R3]
        else $error("count high byte changed while locked");

    property p_low_locked;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && count_low_hit && watchdog_lock && !count_tick) |=>
            $stable(count_value);
    endproperty
    a_low_locked: assert property (p_low_locked) // [R12]
        else $error("count low byte changed while locked");

    property p_enable_clear;
        @(posedge core_clk) disable iff (srst)
        (|wr_low) |=> (comparator_enable & $past(wr_low)) == '0;
    endproperty
    a_enable_clear: assert property (p_enable_clear) // [R9]
        else $error("low byte write did not clear comparator enable");

    property p_enable_set;
        @(posedge core_clk) disable iff (srst)
        (|wr_high) |=> (comparator_enable & $past(wr_high)) == $past(wr_high);
    endproperty
    a_enable_set: assert property (p_enable_set) // [R10]
        else $error("high byte write did not set comparator enable");

    property p_match_gated;
        @(posedge core_clk) disable iff (srst)
        (comparator_enable == '0) |=> match == '0;
    endproperty
    a_match_gated: assert property (p_match_gated) // [R11]
        else $error("match raised with comparator disabled");

    property p_select_routes;
        @(posedge core_clk) disable iff (srst)
        ((|wr_low || |wr_high) && reload_select) |=> $stable(compare_value);
    endproperty
    a_select_routes: assert property (p_select_routes) // [R8]
        else $error("compare value changed with reload selected");

    property p_select_zero;
        @(posedge core_clk) disable iff (srst)
        ((|wr_low || |wr_high) && !reload_select) |=> $stable(reload_value);
    endproperty
    a_select_zero: assert property (p_select_zero) // [R13]
        else $error("reload value changed with compare selected");

    property p_read_timing;
        @(posedge core_clk) disable iff (srst)
        sfr_rd |-> ##2 sfr_rvalid;
    endproperty
    a_read_timing: assert property (p_read_timing) // [R2]
        else $error("read answer not two cycles after strobe");
endmodule

/* design/counter_array_consts.svh */
// constants for the counter array register block
// Functional notes
// R1 - count high byte is a readable, writable byte register resetting to zero.
// R2 - high byte reads return a snapshot loaded only when the low byte is read.
// R3 - writes to the count high byte are ignored while watchdog lock is set.
// R4 - each module has a low byte holding compare value bits 7 to 0, reset zero.
// R5 - each module has a high byte holding compare value bits 15 to 8, reset zero.
// R6 - module low byte address also reaches the low byte of the auto-reload value.
// R7 - module high byte address also reaches the high byte of the auto-reload value.
// R8 - reload select decides whether module addresses reach compare or reload values.
// R9 - any write to a module low byte also forces its comparator enable to zero.
// R10 - any write to a module high byte also forces its comparator enable to one.
// R11 - comparator enable set to one enables matching against the running counter.
// R12 - count low byte is exposed; writes are ignored while watchdog lock is set.
// R13 - reload select zero reaches compare values; one reaches reload values.
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

`define CCR_NUM_MODULES 6
`define CCR_VALUE_W 16
`define CCR_BYTE_W 8

`define CCR_LOW_MSB 7
`define CCR_LOW_LSB 0
`define CCR_HIGH_MSB 15
`define CCR_HIGH_LSB 8

`define CCR_RST_BYTE 8'h00
`define CCR_RST_VALUE 16'h0000
`define CCR_COUNT_STEP 16'h0001

`define CCR_ADDR_COUNT_LOW 8'hF9
`define CCR_ADDR_COUNT_HIGH 8'hFA

`define CCR_ADDR_MOD0_LOW 8'hFB
`define CCR_ADDR_MOD0_HIGH 8'hFC
`define CCR_ADDR_MOD1_LOW 8'hE9
`define CCR_ADDR_MOD1_HIGH 8'hEA
`define CCR_ADDR_MOD2_LOW 8'hEB
`define CCR_ADDR_MOD2_HIGH 8'hEC
`define CCR_ADDR_MOD3_LOW 8'hED
`define CCR_ADDR_MOD3_HIGH 8'hEE
`define CCR_ADDR_MOD4_LOW 8'hFD
`define CCR_ADDR_MOD4_HIGH 8'hFE
`define CCR_ADDR_MOD5_LOW 8'hCE
`define CCR_ADDR_MOD5_HIGH 8'hCF

`endif

/* design/counter_array_pkg.sv */
// types shared by the counter array register block
package counter_array_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_COUNT_LOW = 2'b01,
        SRC_COUNT_HIGH = 2'b10,
        SRC_MODULE = 2'b11
    } read_source_t;
endpackage

/* tb/sfr_host.sv */
// processor core model issuing register bus cycles
`timescale 1ns/1ps
module sfr_host (
    input wire logic core_clk, // system clock
    output logic [7:0] sfr_addr, // address
    output logic sfr_wr, // write strobe
    output logic sfr_rd, // read strobe
    output logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic sfr_rvalid, // read answer
    input wire logic sfr_rhit // mapped read
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        // released data shows no stale value
        sfr_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h,
        output logic v);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        // answer stands for one cycle after the edge following the taking edge
        @(posedge core_clk);
        #1;
        v = sfr_rvalid;
        d = sfr_rdata;
        h = sfr_rhit;
    endtask
endmodule

/* tb/test_counter_array_capture_regs.sv */
// self-checking bench for the counter array register block
`timescale 1ns/1ps
module test_counter_array_capture_regs;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic sfr_rvalid;
    logic sfr_rhit;
    logic count_tick = 1'b0;
    logic watchdog_lock = 1'b0;
    logic reload_select = 1'b0;
    logic [5:0] mode_ecom_wr = 6'h00;
    logic [5:0] mode_ecom_wdata = 6'h00;
    logic [5:0] comparator_enable;
    logic [5:0] match;
    logic [15:0] count_value;
    logic [95:0] compare_value;
    logic [95:0] reload_value;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] lo_addr [6] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hCE};
    logic [7:0] hi_addr [6] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hCF};
    always #2 core_clk = ~core_clk;
    counter_array_capture_regs dut_u (.core_clk(core_clk), .srst(srst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .sfr_rhit(sfr_rhit),
        .count_tick(count_tick), .watchdog_lock(watchdog_lock),
        .reload_select(reload_select), .mode_ecom_wr(mode_ecom_wr),
        .mode_ecom_wdata(mode_ecom_wdata), .comparator_enable(comparator_enable),
        .match(match), .count_value(count_value), .compare_value(compare_value),
        .reload_value(reload_value));
    sfr_host host_u (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid), .sfr_rhit(sfr_rhit));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic h;
        logic v;
        host_u.rd(a, d, h, v);
        chk({7'h00, v, 7'h00, h}, {8'h01, 7'h00, hit});
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic tick();
        @(posedge core_clk);
        count_tick <= 1'b1;
        @(posedge core_clk);
        count_tick <= 1'b0;
        #1;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd_chk(lo_addr[i], 8'h00, 1'b1);
            rd_chk(hi_addr[i], 8'h00, 1'b1);
        end
        rd_chk(8'hF9, 8'h00, 1'b1);
        rd_chk(8'hFA, 8'h00, 1'b1);
        rd_chk(8'h80, 8'h00, 1'b0);
        chk({10'h000, comparator_enable}, 16'h0000);
    endtask
    task automatic t_compare();
        for (int i = 0; i < 6; i++) begin
            host_u.wr(hi_addr[i], 8'h50 + i[7:0]);
            chk({15'h0000, comparator_enable[i]}, 16'h0001);
            host_u.wr(lo_addr[i], 8'hA0 + i[7:0]);
            chk({15'h0000, comparator_enable[i]}, 16'h0000);
            chk(compare_value[16*i+:16], {8'h50 + i[7:0], 8'hA0 + i[7:0]});
            rd_chk(hi_addr[i], 8'h50 + i[7:0], 1'b1);
        end
    endtask
    task automatic t_reload();
        @(posedge core_clk);
        reload_select <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            host_u.wr(lo_addr[i], 8'h30 + i[7:0]);
            host_u.wr(hi_addr[i], 8'hC0 + i[7:0]);
            chk(reload_value[16*i+:16], {8'hC0 + i[7:0], 8'h30 + i[7:0]});
            chk(compare_value[16*i+:16], {8'h50 + i[7:0], 8'hA0 + i[7:0]});
            rd_chk(lo_addr[i], 8'h30 + i[7:0], 1'b1);
        end
        @(posedge core_clk);
        reload_select <= 1'b0;
        rd_chk(lo_addr[0], 8'hA0, 1'b1);
    endtask
    task automatic t_count();
        host_u.wr(8'hF9, 8'hFE);
        host_u.wr(8'hFA, 8'h12);
        chk(count_value, 16'h12FE);
        // snapshot still holds the byte taken at the earlier low read
        rd_chk(8'hFA, 8'h00, 1'b1);
        rd_chk(8'hF9, 8'hFE, 1'b1);
        tick();
        tick();
        chk(count_value, 16'h1300);
        rd_chk(8'hFA, 8'h12, 1'b1);
        rd_chk(8'hF9, 8'h00, 1'b1);
        rd_chk(8'hFA, 8'h13, 1'b1);
    endtask
    task automatic t_lock();
        @(posedge core_clk);
        watchdog_lock <= 1'b1;
        host_u.wr(8'hF9, 8'h55);
        host_u.wr(8'hFA, 8'hAA);
        chk(count_value, 16'h1300);
        @(posedge core_clk);
        watchdog_lock <= 1'b0;
    endtask
    task automatic t_match();
        host_u.wr(8'hFC, 8'h13);
        host_u.wr(8'hFB, 8'h00);
        @(posedge core_clk);
        #1;
        chk({10'h000, match}, 16'h0000);
        @(posedge core_clk);
        mode_ecom_wr <= 6'h01;
        mode_ecom_wdata <= 6'h01;
        @(posedge core_clk);
        mode_ecom_wr <= 6'h00;
        @(posedge core_clk);
        #1;
        chk({10'h000, match}, 16'h0001);
        tick();
        @(posedge core_clk);
        #1;
        chk({10'h000, match}, 16'h0000);
    endtask
    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_compare();
        t_reload();
        t_count();
        t_lock();
        t_match();
        give_verdict();
    end
    // about seventeen times the expected run length
    initial begin
        #(4 * 3000);
        n_mismatch++;
        give_verdict();
    end
endmodule
